// [src/wait_page_pkg.sv]
package wait_page_pkg;
    localparam logic [6:0]  program_page_select_addr = 7'h1E;
    localparam logic [6:0]  wait_state_ranges_addr   = 7'h28;
    localparam logic [6:0]  wait_state_control_addr  = 7'h2B;
    localparam logic [15:0] page_reset               = 16'h0000;
    localparam logic [15:0] ranges_reset             = 16'h7FFF;
    localparam logic [15:0] control_reset            = 16'h0000;
    localparam int          range_select_bit         = 15;
    localparam int          io_lsb                   = 12;
    localparam int          data_hi_lsb              = 9;
    localparam int          data_lo_lsb              = 6;
    localparam int          prog_hi_lsb              = 3;
    localparam int          prog_lo_lsb              = 0;
    localparam int          multiplier_bit           = 0;
    localparam logic [3:0]  page_mask                = 4'hF;
    localparam logic [15:0] overlay_limit            = 16'h3FFF;
    localparam logic [15:0] page0_top                = 16'h007F;
    localparam logic [3:0]  max_waits                = 4'hE;
    typedef enum logic [1:0] {
        space_prog = 2'h0,
        space_data = 2'h1,
        space_io   = 2'h2
    } space_type;
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_wait = 3'h2,
        st_rdy  = 3'h4
    } state_type;
endpackage : wait_page_pkg

// [src/wait_count_select.sv]
`timescale 1ns/1ps
`default_nettype none
module wait_count_select (
    input  wire logic [15:0] ranges,
    input  wire logic        multiplier,
    input  wire logic [1:0]  space,
    input  wire logic [15:0] offset,
    output logic      [3:0]  count
);
    wire logic       whole_prog = ranges[wait_page_pkg::range_select_bit];
    wire logic [2:0] io_f = ranges[wait_page_pkg::io_lsb +: 3];
    wire logic [2:0] dh_f = ranges[wait_page_pkg::data_hi_lsb +: 3];
    wire logic [2:0] dl_f = ranges[wait_page_pkg::data_lo_lsb +: 3];
    wire logic [2:0] ph_f = ranges[wait_page_pkg::prog_hi_lsb +: 3];
    wire logic [2:0] pl_f = ranges[wait_page_pkg::prog_lo_lsb +: 3];
    wire logic [2:0] prog_f =
        (whole_prog || !offset[15]) ? pl_f : ph_f;
    wire logic [2:0] data_f = offset[15] ? dh_f : dl_f;
    wire logic [2:0] base =
        (space == wait_page_pkg::space_io)   ? io_f :
        (space == wait_page_pkg::space_data) ? data_f : prog_f;
    assign count = multiplier ? {base, 1'b0} : {1'b0, base};
endmodule : wait_count_select
`default_nettype wire

// [src/wait_state_gen_with_program_paging.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - drive twenty-bit program address externally
// - page register at 001Eh, reset zero
// - six far transfers load the page
// - other operations keep page unchanged
// - accumulator program read/write use 20 bits
// - sixteen pages of 64K words
// - overlay maps lower 16K on-chip
// - software waits up to fourteen cycles
// - hold cycle until ready asserted
// - gate generator clock when all zero
// - fields reset to 111, select zero
// - bits 14-12 set I/O waits
// - bits 11-9 set upper data waits
// - bits 8-6 set lower data waits
// - bits 5-3 upper program unless select
// - bits 2-0 lower or whole program
// - multiplier doubles base counts
// - control bits 15-1 reserved, unchanged
// - data page 0 never in program
module wait_state_gen_with_program_paging (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // memory-mapped register port from the core
    input  wire logic        mmr_write,
    input  wire logic        mmr_read,
    input  wire logic [6:0]  mmr_addr,
    input  wire logic [15:0] mmr_wdata,
    output logic      [15:0] mmr_rdata,
    // page load from far control transfers
    input  wire logic        far_load,
    input  wire logic [3:0]  far_page,
    // program address from the sequencer (page-relative)
    input  wire logic [15:0] prog_offset,
    input  wire logic        acc_prog_access,
    input  wire logic [19:0] accumulator,
    input  wire logic        ram_overlay_bit,
    output logic      [19:0] program_address,
    output logic             prog_internal,
    // external bus cycle request
    input  wire logic        bus_start,
    input  wire logic [1:0]  bus_space,
    input  wire logic [15:0] bus_offset,
    input  wire logic        ready,
    output logic             bus_hold,
    output logic             bus_done,
    output logic             gen_clock_on
);
    logic [15:0] program_page_register;
    logic [15:0] wait_state_range_register;
    logic [15:0] wait_state_control_register;
    logic [3:0]  count_reg;
    logic [3:0]  count_next;
    wait_page_pkg::state_type state_reg;
    wait_page_pkg::state_type state_next;
    logic [15:0] rdata_next;
    logic [19:0] paddr_next;
    logic        internal_next;
    logic        hold_next;
    logic        done_next;
    logic [3:0]  sel_count;

    // register address decode, shared by writes and reads
    wire logic hit_page =
        mmr_addr == wait_page_pkg::program_page_select_addr;
    wire logic hit_ranges =
        mmr_addr == wait_page_pkg::wait_state_ranges_addr;
    wire logic hit_control =
        mmr_addr == wait_page_pkg::wait_state_control_addr;
    wire logic wr_page    = mmr_write && hit_page;
    wire logic wr_ranges  = mmr_write && hit_ranges;
    wire logic wr_control = mmr_write && hit_control;

    wire logic multiplier =
        wait_state_control_register[wait_page_pkg::multiplier_bit];

    // only the four page bits exist; upper bits read zero
    wire logic [3:0] far_page_bits = far_page & wait_page_pkg::page_mask;
    wire logic [3:0] mmr_page_bits = mmr_wdata[3:0];
    // a far transfer wins over a page write in the same cycle
    wire logic [15:0] page_next =
        far_load ? {12'h000, far_page_bits} :
        wr_page  ? {12'h000, mmr_page_bits} :
        program_page_register;

    // every bit of the range register is writable
    wire logic [15:0] ranges_next =
        wr_ranges ? mmr_wdata : wait_state_range_register;

    // reserved control bits keep their value on writes
    wire logic [15:0] ctrl_next = wr_control ?
        {wait_state_control_register[15:1], mmr_wdata[0]} :
        wait_state_control_register;

    // unmapped addresses read back zero
    assign rdata_next =
        hit_page    ? program_page_register :
        hit_ranges  ? wait_state_range_register :
        hit_control ? wait_state_control_register : 16'h0000;
    // read port idles at zero so a stale word is never taken
    wire logic [15:0] rdata_out = mmr_read ? rdata_next : 16'h0000;

    // program address: page register above the sequencer offset
    wire logic [3:0]  cur_page   = program_page_register[3:0];
    wire logic [19:0] paged_addr = {cur_page, prog_offset};
    // table access takes all twenty bits from the accumulator
    wire logic [3:0]  acc_page   = accumulator[19:16];
    wire logic [15:0] acc_off    = accumulator[15:0];
    assign paddr_next =
        acc_prog_access ? {acc_page, acc_off} : paged_addr;
    wire logic [3:0]  eff_page = paddr_next[19:16];
    wire logic [15:0] eff_off  = paddr_next[15:0];
    wire logic in_page0    = eff_page == 4'h0;
    wire logic below_limit = eff_off <= wait_page_pkg::overlay_limit;
    wire logic above_page0 = eff_off > wait_page_pkg::page0_top;
    // page 0 low region is always on-chip; other pages only with overlay
    assign internal_next =
        (in_page0 || ram_overlay_bit) && below_limit && above_page0;

    // a field counts as idle when it can never add a wait
    wire logic [15:0] ranges_now = wait_state_range_register;
    wire logic whole_prog = ranges_now[wait_page_pkg::range_select_bit];
    wire logic io_zero = ranges_now[wait_page_pkg::io_lsb +: 3] == 3'h0;
    wire logic dh_zero = ranges_now[wait_page_pkg::data_hi_lsb +: 3] == 3'h0;
    wire logic dl_zero = ranges_now[wait_page_pkg::data_lo_lsb +: 3] == 3'h0;
    wire logic ph_zero = ranges_now[wait_page_pkg::prog_hi_lsb +: 3] == 3'h0;
    wire logic pl_zero = ranges_now[wait_page_pkg::prog_lo_lsb +: 3] == 3'h0;
    // upper program field is dead while the whole-space select is set
    wire logic all_zero = io_zero && dh_zero && dl_zero &&
        (ph_zero || whole_prog) && pl_zero;

    wire logic gen_clock_next = !all_zero;

    // one wait count per access, from space and offset
    wait_count_select u_select (
        .ranges     (wait_state_range_register),
        .multiplier (multiplier),
        .space      (bus_space),
        .offset     (bus_offset),
        .count      (sel_count)
    );

    // zero-wait cycles skip the counter: done at once if ready is high, else straight to the ready state
    wire logic need_waits  = sel_count != 4'h0 && !all_zero;
    wire logic start_waits = bus_start && need_waits;
    wire logic start_stall = bus_start && !need_waits && !ready;
    wire logic start_quick = bus_start && !need_waits && ready;
    wire logic last_wait   = count_reg == 4'h1;

    // a start while busy is ignored: only idle looks at bus_start
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            wait_page_pkg::st_idle: begin
                if (start_waits) begin
                    count_next = sel_count;
                    state_next = wait_page_pkg::st_wait;
                end else if (start_stall) begin
                    state_next = wait_page_pkg::st_rdy;
                end
            end
            wait_page_pkg::st_wait: begin
                count_next = count_reg - 4'h1;
                // ready is looked at only once the count has run out
                if (last_wait) begin
                    state_next = wait_page_pkg::st_rdy;
                end
            end
            wait_page_pkg::st_rdy: begin
                if (ready) begin
                    state_next = wait_page_pkg::st_idle;
                end
            end
            default: begin
                // a corrupted one-hot code falls back to idle
                state_next = wait_page_pkg::st_idle;
            end
        endcase
    end

    // hold and done decided per state, both registered below
    always_comb begin
        hold_next = 1'b0;
        done_next = 1'b0;
        unique case (state_reg)
            wait_page_pkg::st_idle: begin
                hold_next = start_waits || start_stall;
                done_next = start_quick;
            end
            wait_page_pkg::st_wait: begin
                hold_next = 1'b1;
            end
            wait_page_pkg::st_rdy: begin
                // hold drops in the cycle that done rises
                hold_next = !ready;
                done_next = ready;
            end
            default: begin
                hold_next = 1'b0;
            end
        endcase
    end

    // every register holds still while clk_en is low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            program_page_register <= wait_page_pkg::page_reset;
        end else if (clk_en) begin
            program_page_register <= page_next;
        end
    end

    // seven waits everywhere after reset, whole-space select clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_state_range_register <= wait_page_pkg::ranges_reset;
        end else if (clk_en) begin
            wait_state_range_register <= ranges_next;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_state_control_register <= wait_page_pkg::control_reset;
        end else if (clk_en) begin
            wait_state_control_register <= ctrl_next;
        end
    end

    // sequencer for one external bus cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= wait_page_pkg::st_idle;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_reg <= 4'h0;
        end else if (clk_en) begin
            count_reg <= count_next;
        end
    end

    // read data stands one cycle per read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mmr_rdata <= 16'h0000;
        end else if (clk_en) begin
            mmr_rdata <= rdata_out;
        end
    end

    // address follows the sequencer, or the accumulator on table access, every cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            program_address <= 20'h00000;
        end else if (clk_en) begin
            program_address <= paddr_next;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_internal <= 1'b0;
        end else if (clk_en) begin
            prog_internal <= internal_next;
        end
    end

    // hold and done come from flops so the bus sees clean edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_hold <= 1'b0;
        end else if (clk_en) begin
            bus_hold <= hold_next;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_done <= 1'b0;
        end else if (clk_en) begin
            bus_done <= done_next;
        end
    end

    // on after reset, since every field then starts at seven
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gen_clock_on <= 1'b1;
        end else if (clk_en) begin
            gen_clock_on <= gen_clock_next;
        end
    end
endmodule : wait_state_gen_with_program_paging
`default_nettype wire

// [tb/wait_page_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module wait_page_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic        mmr_read,
    input wire logic [6:0]  mmr_addr,
    input wire logic [15:0] mmr_rdata,
    input wire logic [15:0] prog_offset,
    input wire logic        acc_prog_access,
    input wire logic [19:0] accumulator,
    input wire logic [19:0] program_address,
    input wire logic        prog_internal,
    input wire logic        ready,
    input wire logic        bus_hold,
    input wire logic        bus_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [4:0] hold_run_reg;
    // counts only ready-high stretch, so slow devices do not trip it
    always_ff @(posedge clk or posedge reset)
        if (reset) hold_run_reg <= 5'h00;
        else if (!bus_hold) hold_run_reg <= 5'h00;
        else if (ready && clk_en) hold_run_reg <= hold_run_reg + 5'h01;
    a_done_pulse: assert property (bus_done |=> !bus_done)
        else $error("bus_done longer than one cycle");
    a_done_ready: assert property (bus_done |-> $past(ready))
        else $error("bus_done without ready");
    a_wait_max: assert property (hold_run_reg <= 5'h0F)
        else $error("stretch beyond fourteen waits");
    a_acc_addr: assert property ($past(acc_prog_access && clk_en && !reset)
        |-> program_address == $past(accumulator))
        else $error("accumulator address not used");
    a_low_bits: assert property ($past(!acc_prog_access && clk_en && !reset)
        |-> program_address[15:0] == $past(prog_offset))
        else $error("word offset wrong");
    a_ctl_read: assert property ($past(mmr_read && clk_en && !reset
        && mmr_addr == 7'h2B) |-> mmr_rdata[15:1] == 15'h0000)
        else $error("control reserved bits nonzero");
    a_page0_out: assert property (prog_internal
        && program_address[19:16] == 4'h0
        |-> program_address[15:7] != 9'h000)
        else $error("data page 0 in program space");
    a_overlay_low: assert property (prog_internal
        |-> program_address[15:14] == 2'h0)
        else $error("internal decode above lower 16K");
    c_done: cover property (bus_done);
    c_acc: cover property (acc_prog_access);
    c_internal: cover property (prog_internal);
endmodule : wait_page_chk
bind wait_state_gen_with_program_paging wait_page_chk i_chk (
    .clk(clk), .reset(reset), .clk_en(clk_en), .mmr_read(mmr_read),
    .mmr_addr(mmr_addr), .mmr_rdata(mmr_rdata), .prog_offset(prog_offset),
    .acc_prog_access(acc_prog_access), .accumulator(accumulator),
    .program_address(program_address), .prog_internal(prog_internal),
    .ready(ready), .bus_hold(bus_hold), .bus_done(bus_done));
`default_nettype wire

// [tb/ext_device.sv]
`timescale 1ns/1ps
`default_nettype none
module ext_device (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       bus_start,
    input  wire logic [4:0] slow,
    output logic            ready
);
    logic [4:0] cnt_reg;
    always_ff @(posedge clk or posedge reset)
        if (reset) cnt_reg <= 5'h00;
        else if (bus_start) cnt_reg <= slow;
        else if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
    // a slow device pulls ready low as soon as it is addressed
    assign ready = cnt_reg == 5'h00 && !(bus_start && slow != 5'h00);
endmodule : ext_device
`default_nettype wire

// [tb/wait_state_gen_with_program_paging_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module wait_state_gen_with_program_paging_tb;
    logic clk = 0, reset = 1, clk_en = 1, mmr_write = 0, mmr_read = 0;
    logic far_load = 0, acc_prog_access = 0, ram_overlay_bit = 0;
    logic bus_start = 0;
    logic [6:0] mmr_addr = 0;
    logic [15:0] mmr_wdata = 0, prog_offset = 0, bus_offset = 0, rng, ctl;
    logic [3:0] far_page = 0;
    logic [4:0] slow = 0;
    logic [19:0] accumulator = 0;
    logic [1:0] bus_space = 0;
    wire logic ready, prog_internal, bus_hold, bus_done, gen_clock_on;
    wire logic [15:0] mmr_rdata;
    wire logic [19:0] program_address;
    int error_cnt = 0, checks = 0, seed = 32'hA8EEAAE0, i, d;
    always #5 clk = ~clk;
    wait_state_gen_with_program_paging i_dut (
        .clk(clk), .reset(reset), .clk_en(clk_en), .mmr_write(mmr_write),
        .mmr_read(mmr_read), .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata),
        .mmr_rdata(mmr_rdata), .far_load(far_load), .far_page(far_page),
        .prog_offset(prog_offset), .acc_prog_access(acc_prog_access),
        .accumulator(accumulator), .ram_overlay_bit(ram_overlay_bit),
        .program_address(program_address), .prog_internal(prog_internal),
        .bus_start(bus_start), .bus_space(bus_space),
        .bus_offset(bus_offset), .ready(ready), .bus_hold(bus_hold),
        .bus_done(bus_done), .gen_clock_on(gen_clock_on));
    ext_device i_dev (.clk(clk), .reset(reset), .bus_start(bus_start),
        .slow(slow), .ready(ready));
    task print_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task chk(string n, logic [19:0] e, logic [19:0] s);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task wr(logic [6:0] a, logic [15:0] v);
        @(negedge clk);
        mmr_addr = a; mmr_wdata = v; mmr_write = 1;
        @(negedge clk) mmr_write = 0;
    endtask : wr
    task rd(logic [6:0] a, logic [15:0] e);
        @(negedge clk);
        mmr_addr = a; mmr_read = 1;
        @(negedge clk) mmr_read = 0;
        chk("mmr_rdata", e, mmr_rdata);
    endtask : rd
    function int exp_n(logic [1:0] sp, logic [15:0] o);
        logic [2:0] f;
        f = sp == 2'h2 ? rng[14:12] : sp == 2'h1 ?
            (o[15] ? rng[11:9] : rng[8:6]) :
            (o[15] && !rng[15] ? rng[5:3] : rng[2:0]);
        return ctl[0] ? 2 * f : f;
    endfunction : exp_n
    // zero waits finish at the start edge, else count plus the ready stage
    function int cyc(int n);
        return n == 0 ? 0 : n + 1;
    endfunction : cyc
    task bus(logic [1:0] sp, logic [15:0] o, int lo, int hi);
        bus_space = sp; bus_offset = o; bus_start = 1; d = 0;
        @(negedge clk) bus_start = 0;
        chk("bus_hold", lo > 0, bus_hold);
        while (bus_done !== 1'b1 && d < 60) begin
            d++;
            @(negedge clk);
        end
        checks++;
        if (d < lo || d > hi) begin
            error_cnt++;
            $display("unexpected bus_cycles exp %0d got %0d", lo, d);
        end
        if (d == 60) print_verdict;
    endtask : bus
    initial begin
        repeat (10) @(negedge clk);
        reset = 0;
        rd(7'h1E, 16'h0000);
        rd(7'h28, 16'h7FFF);
        rng = 16'h7FFF;
        wr(7'h2B, 16'hFFFF);
        ctl = 16'h0001;
        rd(7'h2B, ctl);
        bus(2'h1, 16'h8000, 15, 16);
        for (i = 0; i < 12; i++) begin
            rng = $random(seed);
            wr(7'h28, rng);
            rd(7'h28, rng);
            wr(7'h2B, $random(seed));
            ctl = {15'h0000, mmr_wdata[0]};
            bus_offset = $random(seed);
            d = cyc(exp_n(i % 3, bus_offset));
            bus(i % 3, bus_offset, d, d);
        end
        wr(7'h1E, 16'hFFF5);
        prog_offset = 16'h1234;
        @(negedge clk);
        chk("program_address", 20'h51234, program_address);
        for (i = 0; i < 6; i++) begin
            far_page = $random(seed);
            far_load = 1;
            @(negedge clk) far_load = 0;
            prog_offset = $random(seed);
            repeat (2) @(negedge clk);
            chk("program_address", {far_page, prog_offset}, program_address);
        end
        accumulator = 20'hC8765;
        acc_prog_access = 1;
        @(negedge clk) acc_prog_access = 0;
        chk("program_address", accumulator, program_address);
        wr(7'h1E, 16'h0009);
        ram_overlay_bit = 1;
        prog_offset = 16'h2000;
        repeat (2) @(negedge clk);
        chk("prog_internal", 1, prog_internal);
        ram_overlay_bit = 0;
        repeat (2) @(negedge clk);
        chk("prog_internal", 0, prog_internal);
        wr(7'h1E, 16'h0000);
        ram_overlay_bit = 1;
        prog_offset = 16'h0040;
        repeat (2) @(negedge clk);
        chk("prog_internal", 0, prog_internal);
        wr(7'h28, 16'h8000);
        @(negedge clk);
        chk("gen_clock_on", 0, gen_clock_on);
        slow = 5'd20;
        bus(2'h0, 16'h0000, 21, 23);
        print_verdict;
    end
endmodule : wait_state_gen_with_program_paging_tb
`default_nettype wire
